//--- eeprom_pkg.sv
`default_nettype none
package eeprom_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int WRITE_TIME_MS = 10;
  // Longest time, an exact whole number of cycles with no rounding
  localparam int WRITE_CYCLES = WRITE_TIME_MS * 1000 * CLK_MHZ;
  localparam int SCL_QUARTER_NS = 625;
  localparam int SCL_QUARTER_CYCLES = (SCL_QUARTER_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================
  // Array and addressing byte layout
  localparam int MEM_DEPTH = 512;
  localparam int PAGE_BYTES = 16;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] DEVICE_TYPE = 4'h5; // Arbitrary value
  localparam int CTL_RW_BIT = 0;
  localparam int CTL_BANK_BIT = 1;
  localparam int CTL_SEL_LSB = 2;
  localparam int CTL_TYPE_LSB = 4;

  // ==========================================================
  // Controller registers (byte addresses)
  localparam logic [3:0] REG_TXDATA = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int CMD_READ_BIT = 2;
  localparam int CMD_STOP_BIT = 3;
  localparam int CMD_NACK_BIT = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_RX_LSB = 8;

  // ==========================================================
  // State encodings
  typedef enum logic [3:0] {
    DEV_IDLE = 4'h0,
    DEV_CTRL = 4'h1,
    DEV_WADDR = 4'h2,
    DEV_WDATA = 4'h3,
    DEV_ACK = 4'h4,
    DEV_TX = 4'h5,
    DEV_MACK = 4'h6,
    DEV_PROG = 4'h7
  } dev_state_e;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_START = 2'h1,
    H_BIT = 2'h2,
    H_STOP = 2'h3
  } host_state_e;
endpackage : eeprom_pkg
`default_nettype wire

//--- two_wire_if.sv
`default_nettype none
interface two_wire_if;
  // ==========================================================
  // Clock line is push-pull from the master; data line is wired-AND
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Pull-up wins unless some end drives low
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : two_wire_if
`default_nettype wire

//--- bit_sync.sv
`default_nettype none
module bit_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // ==========================================================
  // Two stages; the first is read only by the second
  always_comb
  begin
    meta_nxt = d_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign q_o = sync_r;
endmodule : bit_sync
`default_nettype wire

//--- eeprom_device.sv
// Overview of operation
// RQ1 - Write addressing byte then 8-bit word address
// RQ2 - Acknowledge word address and data byte
// RQ3 - Programming starts only on STOP
// RQ4 - Ignore bus while programming runs
// RQ5 - Page write carries up to 16 bytes
// RQ6 - Acknowledge each byte, bump low nibble only
// RQ7 - Extra bytes wrap and overwrite the page
// RQ8 - Acknowledge addressing byte only when not programming
// RQ9 - Direction bit one selects read
// RQ10 - Counter holds last location plus one
// RQ11 - Read: acknowledge then send counter byte
// RQ12 - Master ends read with no-acknowledge, STOP
// RQ13 - Random read loads counter via dummy write
// RQ14 - Master acknowledge: increment, send next byte
// RQ15 - Sequential read wraps 255 to 0
// RQ16 - Bank bit is word address top bit
// RQ17 - Match device bits against select pins
// RQ18 - Write protect blocks programming, reads unaffected
// RQ19 - Programming ends within 10 ms
// RQ20 - Mismatched addressing byte: no acknowledge, idle
`default_nettype none
module eeprom_device #(
  parameter int WRITE_CYCLES_P = eeprom_pkg::WRITE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  two_wire_if.dev link,
  input wire logic write_protect_input_i,
  input wire logic select_pin_low_i,
  input wire logic select_pin_high_i,
  output logic busy_o
);
  import eeprom_pkg::*;

  localparam int TIMER_W = $clog2(WRITE_CYCLES_P + 1);

  logic [4:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [1:0] sel_s;
  logic scl_p_r;
  logic sda_p_r;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  dev_state_e state_r;
  dev_state_e state_nxt;
  dev_state_e next_r;
  dev_state_e next_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] rx_r;
  logic [7:0] rx_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic [8:0] addr_r;
  logic [8:0] addr_nxt;
  logic oe_r;
  logic oe_nxt;
  logic mack_r;
  logic mack_nxt;
  logic [PAGE_BYTES-1:0] mask_r;
  logic [PAGE_BYTES-1:0] mask_nxt;
  logic [TIMER_W-1:0] prog_r;
  logic [TIMER_W-1:0] prog_nxt;
  logic busy_r;
  logic buf_we;
  logic commit;
  logic [7:0] buf_r [PAGE_BYTES];
  logic [7:0] buf_nxt [PAGE_BYTES];
  logic [7:0] mem_r [MEM_DEPTH];
  logic [7:0] mem_nxt [MEM_DEPTH];

  // ==========================================================
  // Pin synchronisers and bus event detection
  bit_sync #(
    .W(5),
    .RESET_VAL(5'h1F)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({link.scl, link.sda, write_protect_input_i, select_pin_high_i, select_pin_low_i}),
    .q_o(pins_s)
  );

  assign scl_s = pins_s[4];
  assign sda_s = pins_s[3];
  assign wp_s = pins_s[2];
  assign sel_s = pins_s[1:0];

  // Previous line levels, reset to the idle-high bus
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end
    else
    begin
      scl_p_r <= scl_s;
      sda_p_r <= sda_s;
    end
  end

  // Data edges while the clock is high frame a transfer
  assign scl_rise = scl_s && !scl_p_r;
  assign scl_fall = !scl_s && scl_p_r;
  assign start_seen = scl_s && scl_p_r && sda_p_r && !sda_s;
  assign stop_seen = scl_s && scl_p_r && !sda_p_r && sda_s;

  // ==========================================================
  // Protocol engine
  always_comb
  begin
    state_nxt = state_r;
    next_nxt = next_r;
    cnt_nxt = cnt_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    addr_nxt = addr_r;
    oe_nxt = oe_r;
    mack_nxt = mack_r;
    mask_nxt = mask_r;
    prog_nxt = prog_r;
    buf_we = 1'b0;
    commit = 1'b0;
    if (state_r == DEV_PROG)
    begin
      // Deaf to the bus, so polls go unanswered
      oe_nxt = 1'b0; // see RQ4, see RQ8
      if (prog_r == TIMER_W'(WRITE_CYCLES_P - 1)) // see RQ19
      begin
        commit = 1'b1;
        mask_nxt = '0;
        prog_nxt = '0;
        state_nxt = DEV_IDLE;
      end
      else
      begin
        prog_nxt = prog_r + 1'b1;
      end
    end
    else if (start_seen)
    begin
      // Unfinished writes are dropped by a new start
      state_nxt = DEV_CTRL;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
      mask_nxt = '0;
    end
    else if (stop_seen)
    begin
      oe_nxt = 1'b0;
      cnt_nxt = 4'h0;
      if (mask_r != '0 && !wp_s) // see RQ3, see RQ18
      begin
        state_nxt = DEV_PROG;
      end
      else
      begin
        mask_nxt = '0;
        state_nxt = DEV_IDLE;
      end
    end
    else
    begin
      unique case (state_r)
        DEV_IDLE:
        begin
          oe_nxt = 1'b0;
        end
        DEV_CTRL, DEV_WADDR, DEV_WDATA:
        begin
          if (scl_rise)
          begin
            rx_nxt = {rx_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (scl_fall && cnt_r == BITS_PER_BYTE)
          begin
            cnt_nxt = 4'h0;
            oe_nxt = 1'b1; // see RQ2, see RQ6
            state_nxt = DEV_ACK;
            if (state_r == DEV_CTRL)
            begin
              if (rx_r[7:CTL_TYPE_LSB] != DEVICE_TYPE || rx_r[CTL_TYPE_LSB-1:CTL_SEL_LSB] != sel_s) // see RQ17
              begin
                oe_nxt = 1'b0; // see RQ20
                state_nxt = DEV_IDLE;
              end
              else if (rx_r[CTL_RW_BIT]) // see RQ9
              begin
                // Current location goes out, counter moves past it
                tx_nxt = mem_r[{rx_r[CTL_BANK_BIT], addr_r[7:0]}]; // see RQ11
                addr_nxt = {rx_r[CTL_BANK_BIT], addr_r[7:0] + 8'h01}; // see RQ10, see RQ16
                next_nxt = DEV_TX;
              end
              else
              begin
                addr_nxt[8] = rx_r[CTL_BANK_BIT]; // see RQ16
                next_nxt = DEV_WADDR;
              end
            end
            else if (state_r == DEV_WADDR)
            begin
              addr_nxt = {addr_r[8], rx_r}; // see RQ1, see RQ13
              next_nxt = DEV_WDATA;
            end
            else
            begin
              // Only the low nibble moves, so a long page wraps on itself
              buf_we = 1'b1;
              mask_nxt[addr_r[3:0]] = 1'b1; // see RQ5, see RQ7
              addr_nxt[3:0] = addr_r[3:0] + 4'h1; // see RQ6, see RQ10
              next_nxt = DEV_WDATA;
            end
          end
        end
        DEV_ACK:
        begin
          if (scl_fall)
          begin
            state_nxt = next_r;
            oe_nxt = 1'b0;
            if (next_r == DEV_TX)
            begin
              oe_nxt = !tx_r[7];
              tx_nxt = {tx_r[6:0], 1'b0};
              cnt_nxt = 4'h1;
            end
          end
        end
        DEV_TX:
        begin
          if (scl_fall)
          begin
            if (cnt_r == BITS_PER_BYTE)
            begin
              oe_nxt = 1'b0;
              cnt_nxt = 4'h0;
              state_nxt = DEV_MACK;
            end
            else
            begin
              oe_nxt = !tx_r[7];
              tx_nxt = {tx_r[6:0], 1'b0};
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        DEV_MACK:
        begin
          if (scl_rise)
          begin
            mack_nxt = !sda_s;
            if (!sda_s)
            begin
              // Low eight bits roll over, bank bit holds
              tx_nxt = mem_r[addr_r]; // see RQ14
              addr_nxt = {addr_r[8], addr_r[7:0] + 8'h01}; // see RQ15
            end
          end
          else if (scl_fall)
          begin
            if (mack_r)
            begin
              oe_nxt = !tx_r[7];
              tx_nxt = {tx_r[6:0], 1'b0};
              cnt_nxt = 4'h1;
              state_nxt = DEV_TX;
            end
            else
            begin
              state_nxt = DEV_IDLE; // see RQ12
            end
          end
        end
        DEV_PROG:
        begin
          state_nxt = DEV_PROG;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= DEV_IDLE;
      next_r <= DEV_IDLE;
      cnt_r <= 4'h0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      addr_r <= 9'h000;
      oe_r <= 1'b0;
      mack_r <= 1'b0;
      mask_r <= '0;
      prog_r <= '0;
      busy_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      next_r <= next_nxt;
      cnt_r <= cnt_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      addr_r <= addr_nxt;
      oe_r <= oe_nxt;
      mack_r <= mack_nxt;
      mask_r <= mask_nxt;
      prog_r <= prog_nxt;
      busy_r <= (state_nxt == DEV_PROG);
    end
  end

  // ==========================================================
  // Page buffer and array; contents survive reset on purpose
  always_comb
  begin
    buf_nxt = buf_r;
    mem_nxt = mem_r;
    if (buf_we)
    begin
      buf_nxt[addr_r[3:0]] = rx_r;
    end
    if (commit)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        if (mask_r[i])
        begin
          mem_nxt[{addr_r[8:4], i[3:0]}] = buf_r[i]; // see RQ3
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    buf_r <= buf_nxt;
    mem_r <= mem_nxt;
  end

  // Open-drain: the output level is always low
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = oe_r;
  assign busy_o = busy_r;
endmodule : eeprom_device
`default_nettype wire

//--- eeprom_host.sv
`default_nettype none
module eeprom_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  two_wire_if.host link
);
  import eeprom_pkg::*;

  localparam logic [7:0] QUARTER_LAST = 8'(SCL_QUARTER_CYCLES - 1);

  logic sda_s;
  host_state_e state_r;
  host_state_e state_nxt;
  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic [1:0] q_r;
  logic [1:0] q_nxt;
  logic [3:0] bitn_r;
  logic [3:0] bitn_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [4:0] cmd_r;
  logic [4:0] cmd_nxt;
  logic [7:0] txd_r;
  logic [7:0] txd_nxt;
  logic [7:0] rxd_r;
  logic [7:0] rxd_nxt;
  logic nack_r;
  logic nack_nxt;
  logic scl_r;
  logic scl_nxt;
  logic oe_r;
  logic oe_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic req;
  logic tick;

  bit_sync #(
    .W(1),
    .RESET_VAL(1'b1)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(link.sda),
    .q_o(sda_s)
  );

  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign tick = (state_r != H_IDLE) && (div_r == QUARTER_LAST);

  // ==========================================================
  // Register slave and quarter-bit sequencer
  always_comb
  begin
    state_nxt = state_r;
    div_nxt = (state_r == H_IDLE || tick) ? 8'h00 : div_r + 8'h01;
    q_nxt = q_r;
    bitn_nxt = bitn_r;
    sh_nxt = sh_r;
    cmd_nxt = cmd_r;
    txd_nxt = txd_r;
    rxd_nxt = rxd_r;
    nack_nxt = nack_r;
    scl_nxt = scl_r;
    oe_nxt = oe_r;
    ack_nxt = req;
    dat_nxt = 32'h0000_0000;
    if (req && !wb_we_i)
    begin
      if (wb_adr_i == REG_TXDATA)
      begin
        dat_nxt = {24'h000000, txd_r};
      end
      else if (wb_adr_i == REG_STATUS)
      begin
        dat_nxt = {16'h0000, rxd_r, 6'h00, nack_r, state_r != H_IDLE};
      end
    end
    if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_TXDATA)
    begin
      txd_nxt = wb_dat_i[7:0];
    end
    // Commands are ignored while a sequence is running
    if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CMD && state_r == H_IDLE)
    begin
      cmd_nxt = wb_dat_i[4:0];
      nack_nxt = 1'b0;
      q_nxt = 2'h0;
      bitn_nxt = 4'h0;
      sh_nxt = txd_r;
      if (wb_dat_i[CMD_START_BIT])
        state_nxt = H_START;
      else if (wb_dat_i[CMD_WRITE_BIT] || wb_dat_i[CMD_READ_BIT])
        state_nxt = H_BIT;
      else if (wb_dat_i[CMD_STOP_BIT])
        state_nxt = H_STOP;
    end
    else if (tick)
    begin
      q_nxt = q_r + 2'h1;
      unique case (state_r)
        H_IDLE:
        begin
          q_nxt = 2'h0;
        end
        H_START:
        begin
          // Data falls while clock is high; also serves as repeated start
          unique case (q_r)
            2'h0:
            begin
              scl_nxt = 1'b0;
              oe_nxt = 1'b0;
            end
            2'h1: scl_nxt = 1'b1;
            2'h2: oe_nxt = 1'b1; // see RQ8, see RQ13
            2'h3:
            begin
              scl_nxt = 1'b0;
              if (cmd_r[CMD_WRITE_BIT] || cmd_r[CMD_READ_BIT])
                state_nxt = H_BIT;
              else if (cmd_r[CMD_STOP_BIT])
                state_nxt = H_STOP;
              else
                state_nxt = H_IDLE;
            end
          endcase
        end
        H_BIT:
        begin
          unique case (q_r)
            2'h0:
            begin
              // Addressing byte, word address and data all go out MSB first
              if (bitn_r != BITS_PER_BYTE)
                oe_nxt = cmd_r[CMD_WRITE_BIT] && !sh_r[7]; // see RQ1, see RQ5, see RQ9
              else
                oe_nxt = cmd_r[CMD_READ_BIT] && !cmd_r[CMD_NACK_BIT]; // see RQ12
            end
            2'h1: scl_nxt = 1'b1;
            2'h2:
            begin
              if (bitn_r != BITS_PER_BYTE)
                sh_nxt = {sh_r[6:0], sda_s};
              else if (cmd_r[CMD_WRITE_BIT])
                nack_nxt = sda_s; // see RQ8
            end
            2'h3:
            begin
              scl_nxt = 1'b0;
              bitn_nxt = bitn_r + 4'h1;
              if (bitn_r == BITS_PER_BYTE)
              begin
                if (cmd_r[CMD_READ_BIT])
                  rxd_nxt = sh_r;
                oe_nxt = 1'b0;
                state_nxt = cmd_r[CMD_STOP_BIT] ? H_STOP : H_IDLE;
              end
            end
          endcase
        end
        H_STOP:
        begin
          // Data rises while clock is high; starts the device's write cycle
          unique case (q_r)
            2'h0:
            begin
              scl_nxt = 1'b0;
              oe_nxt = 1'b1;
            end
            2'h1: scl_nxt = 1'b1;
            2'h2: oe_nxt = 1'b0; // see RQ3, see RQ12
            2'h3: state_nxt = H_IDLE;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= H_IDLE;
      div_r <= 8'h00;
      q_r <= 2'h0;
      bitn_r <= 4'h0;
      sh_r <= 8'h00;
      cmd_r <= 5'h00;
      txd_r <= 8'h00;
      rxd_r <= 8'h00;
      nack_r <= 1'b0;
      scl_r <= 1'b1;
      oe_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      div_r <= div_nxt;
      q_r <= q_nxt;
      bitn_r <= bitn_nxt;
      sh_r <= sh_nxt;
      cmd_r <= cmd_nxt;
      txd_r <= txd_nxt;
      rxd_r <= rxd_nxt;
      nack_r <= nack_nxt;
      scl_r <= scl_nxt;
      oe_r <= oe_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign link.scl = scl_r;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = oe_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
endmodule : eeprom_host
`default_nettype wire

//--- eeprom_top_note_unused.sv
`default_nettype none
`default_nettype wire

//--- eeprom_link_monitor.sv
`default_nettype none
module eeprom_link_monitor #(
  parameter int WRITE_CYCLES_P = 200
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda,
  input wire logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Helper counters
  int busy_cnt_r;
  int stop_age_r;
  logic sda_q_r;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Length of the busy level and age of the last STOP seen on the raw wire
  always_ff @(posedge clk_i)
  begin
    sda_q_r <= sda;
    busy_cnt_r <= (rst_i || !busy_o) ? 0 : busy_cnt_r + 1;
    stop_age_r <= (scl && sda && !sda_q_r) ? 0 : ((rst_i || stop_age_r > 999) ? 1000 : stop_age_r + 1);
  end

  // ==========================================================
  // Properties
  AST_RESET_IDLE: assert property ($fell(rst_i) |-> scl && !dev_sda_oe && !host_sda_oe && !busy_o)
    else $error("link not idle after reset");
  AST_DEV_OPEN_DRAIN: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives data high");
  AST_HOST_OPEN_DRAIN: assert property (host_sda_oe |-> !host_sda_o)
    else $error("host drives data high");
  AST_DEV_CHANGE_LOW: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl, 2))
    else $error("device changed data while clock high");
  AST_BUSY_QUIET: assert property (busy_o |-> !dev_sda_oe)
    else $error("device answered while programming");
  AST_BUSY_BOUND: assert property (busy_o |-> busy_cnt_r < WRITE_CYCLES_P)
    else $error("programming ran too long");
  AST_BUSY_AFTER_STOP: assert property ($rose(busy_o) |-> stop_age_r < 8)
    else $error("programming began without a STOP");
  AST_SCL_HIGH_HOLD: assert property ($rose(scl) |=> scl [*8])
    else $error("clock high phase too short");
endmodule : eeprom_link_monitor
`default_nettype wire

//--- testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import eeprom_pkg::*;
  // First poll's START lands inside programming, the second one after it
  localparam int WCP = 2000;
  localparam logic [31:0] C_S = 32'h1 << CMD_START_BIT;
  localparam logic [31:0] C_W = 32'h1 << CMD_WRITE_BIT;
  localparam logic [31:0] C_R = 32'h1 << CMD_READ_BIT;
  localparam logic [31:0] C_P = 32'h1 << CMD_STOP_BIT;
  localparam logic [31:0] C_N = 32'h1 << CMD_NACK_BIT;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, busy;
  logic wp = 1'b0, sel_lo = 1'b0, sel_hi = 1'b0;
  logic [3:0] wb_adr = 4'h0;
  logic [31:0] wb_dat = 32'h0, wb_rdat;
  logic [7:0] d [4];
  logic [7:0] mem [int];
  int n_mismatch = 0, num_checks = 0, ctr;

  two_wire_if link_if ();
  eeprom_host eeprom_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .link(link_if.host));
  eeprom_device #(.WRITE_CYCLES_P(WCP)) eeprom_device_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link_if.dev),
    .write_protect_input_i(wp), .select_pin_low_i(sel_lo), .select_pin_high_i(sel_hi), .busy_o(busy));
  eeprom_link_monitor #(.WRITE_CYCLES_P(WCP)) mon (.clk_i(clk_i), .rst_i(rst_i), .scl(link_if.scl),
    .host_sda_o(link_if.host_sda_o), .host_sda_oe(link_if.host_sda_oe), .dev_sda_o(link_if.dev_sda_o),
    .dev_sda_oe(link_if.dev_sda_oe), .sda(link_if.sda), .busy_o(busy));

  // Clock
  always #2.5 clk_i = ~clk_i;

  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // Classic cycle: hold until ack is sampled, then release for one cycle
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= wd;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // One byte on the link, then poll until the controller is idle
  task automatic xfer(input logic [31:0] cmd, input logic [7:0] tx, output logic [31:0] st);
    logic [31:0] r;
    wb(1'b1, REG_TXDATA, {24'h0, tx}, r);
    wb(1'b1, REG_CMD, cmd, r);
    st = 32'h1;
    for (int i = 0; i < 5000 && st[STAT_BUSY_BIT] !== 1'b0; i++)
      wb(1'b0, REG_STATUS, 32'h0, st);
    // A sequence that never ends counts as a failure
    if (st[STAT_BUSY_BIT] !== 1'b0)
      n_mismatch++;
  endtask : xfer

  task automatic snd(input logic [31:0] cmd, input logic [7:0] tx, input logic nack);
    logic [31:0] st;
    xfer(cmd, tx, st);
    check(32'(st[STAT_NACK_BIT]), 32'(nack));
  endtask : snd

  task automatic rcv(input logic [31:0] cmd, input logic [7:0] exp);
    logic [31:0] st;
    xfer(cmd, 8'h00, st);
    check(32'(st[STAT_RX_LSB +: 8]), 32'(exp));
  endtask : rcv

  // Acknowledge polling; the first try falls inside programming
  task automatic poll();
    logic [31:0] st;
    int k;
    k = 0;
    do
    begin
      xfer(C_S | C_W, ctl(1'b0), st);
      k++;
    end
    while (st[STAT_NACK_BIT] !== 1'b0 && k < 8);
    check(32'(k > 1), 32'h1);
    check(32'(st[STAT_NACK_BIT]), 32'h0);
  endtask : poll

  // Addressing byte, always bank one so the top address bit is exercised
  function automatic logic [7:0] ctl(input logic rd);
    return {DEVICE_TYPE, sel_hi, sel_lo, 1'b1, rd};
  endfunction : ctl

  // Sequential read counter keeps the bank bit, low byte wraps
  function automatic int nxt(input int a);
    return (a & 256) | ((a + 1) & 255);
  endfunction : nxt

  // ==========================================================
  // Main sequence
  initial
  begin
    ctr = $urandom(32'hC6D76316);
    foreach (d[i]) d[i] = 8'($urandom());
    @(posedge clk_i);
    sel_lo <= 1'($urandom());
    sel_hi <= 1'($urandom());
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Page write that runs off the page end and wraps within it
    snd(C_S | C_W, ctl(1'b0), 1'b0);
    snd(C_W, 8'hFE, 1'b0);
    snd(C_W, d[0], 1'b0);
    snd(C_W, d[1], 1'b0);
    snd(C_W | C_P, d[2], 1'b0);
    foreach (d[i]) if (i < 3) mem[9'h1F0 | ((14 + i) & 15)] = d[i];
    poll();
    snd(C_W, 8'h00, 1'b0);
    snd(C_W | C_P, d[3], 1'b0);
    mem[9'h100] = d[3];
    $display("test write done");
    poll();
    // Protected write is acked but never programs; the reads below prove it
    wp <= 1'b1;
    snd(C_S | C_W, ctl(1'b0), 1'b0);
    snd(C_W, 8'hFE, 1'b0);
    snd(C_W | C_P, ~d[0], 1'b0);
    repeat (20) @(posedge clk_i);
    check(32'(busy), 32'h0);
    $display("test protect done");
    // Wrong select pins, then wrong device type: both left unanswered
    snd(C_S | C_W, ctl(1'b0) ^ 8'h0C, 1'b1);
    snd(C_S | C_W, ctl(1'b0) ^ 8'h80, 1'b1);
    // Random read of one byte, then a current address read across the wrap
    snd(C_S | C_W, ctl(1'b0), 1'b0);
    snd(C_W, 8'hFE, 1'b0);
    snd(C_S | C_W, ctl(1'b1), 1'b0);
    ctr = 9'h1FE;
    rcv(C_R | C_N | C_P, mem[ctr]);
    snd(C_S | C_W, ctl(1'b1), 1'b0);
    ctr = nxt(ctr);
    rcv(C_R, mem[ctr]);
    ctr = nxt(ctr);
    rcv(C_R | C_N | C_P, mem[ctr]);
    $display("test read done");
    tally_and_finish();
  end

  // Watchdog sized from roughly fifty link bytes
  initial
  begin
    repeat (250000) @(posedge clk_i);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
